// ===== rtl/lrp_device.sv
`timescale 1ns/1ps
// What this block does
// - three-level interrupt status, three 16-bit reads
// - level enable masks everything below it
// - clearing latched bit removes pending interrupt
// - hardware mode: reset pin, shared power-down pins
// - processor mode: global, port reset, power-down bits
// - reset pin OR software bit forms global reset
// - software reset bit sticky, cleared by write/pin
// - global reset OR port bit forms port reset
// - port reset bit sticky, cleared by write/global
// - data-path reset spares control registers
// - host holds data-path reset while configuring
// - global data-path bit forced during global reset
// - port data-path bit forced during port reset
// - reset asserts asynchronously, control leaves clockless
// - power-down gates port clocks and analog
// - adapter off at zero mode, global never off
// - after reset data-path and power-down bits set
// - host clears power-down, configures, then releases
// - data bus floats only on reset pin
// - pins safe during reset, line outputs float
// - host holds reset bits at least 100ns
// - powered-up circuits ready after about 1ms
// - top_control_one bit0 reset, bit1 data-path reset
// - interrupt pin low when enabled source active
module lrp_device (
   input wire logic clk_in,
   input wire logic rst_n_in,
   lrp_if.dev bus,
   input wire logic [3:0] global_event_in,
   input wire logic [15:0] port_event_in [lrp_pkg::NUM_PORTS],
   input wire logic [15:0] block_event_in [lrp_pkg::NUM_PORTS],
   input wire logic one_sec_ref_present_in,
   output logic [3:0] tx_clock_gate_out,
   output logic [3:0] rx_clock_gate_out,
   output logic [3:0] tx_powerdown_out,
   output logic [3:0] rx_powerdown_out,
   output logic [3:0] port_ready_out,
   output logic [3:0] line_out_oe_out,
   output logic [3:0] port_reset_out,
   output logic [3:0] port_dp_reset_out,
   output logic global_reset_out,
   output logic global_dp_reset_out,
   output logic adapter_powerdown_out,
   output logic one_sec_powerdown_out,
   output logic gp_pins_input_out,
   output logic adapter_clock_pins_ref_out,
   output logic test_reset_out
);
   localparam int NP = lrp_pkg::NUM_PORTS;

   // three-stage pin synchronisers; change counts when stages 2 and 3 agree
   logic [2:0] hwtx_sync_ff;
   logic [2:0] hwrx_sync_ff;
   logic hw_tx_pd_ff;
   logic hw_rx_pd_ff;

   logic [15:0] ctl1_ff;
   logic [15:0] ctl2_ff;
   logic [15:0] top_en_ff;
   logic [15:0] pctl_ff [NP];
   logic [15:0] pen_ff [NP];
   logic [15:0] ben_ff [NP];
   logic [15:0] rdata_ff;
   logic rvalid_ff;
   logic [15:0] top_latched;
   logic [15:0] port_latched [NP];
   logic [15:0] blk_latched [NP];
   logic [3:0] port_int;
   logic [NP-1:0] port_sel;
   logic [NP-1:0] port_rst;

   // hardware mode ignores every software reset and power-down bit except the global data-path bit at global_dp_reset_out
   wire logic hw_mode = bus.interface_select[2:1] == lrp_pkg::IF_SEL_HW;
   wire logic pin_rst = !bus.rst_pin_n;
   // global reset: pin OR sticky software bit, asserted combinationally
   wire logic global_rst = pin_rst | (!hw_mode & ctl1_ff[lrp_pkg::SW_RESET_BIT]);
   wire logic clr_on_read = ctl2_ff[lrp_pkg::LATCH_CLEAR_READ_BIT];
   wire logic wr_top1 = bus.wr_stb && bus.addr == lrp_pkg::TOP_CONTROL_ONE_ADDR;
   wire logic wr_top2 = bus.wr_stb && bus.addr == lrp_pkg::TOP_CONTROL_TWO_ADDR;
   wire logic wr_topen = bus.wr_stb && bus.addr == lrp_pkg::TOP_INT_ENABLE_ADDR;
   wire logic wr_toplat = bus.wr_stb && bus.addr == lrp_pkg::TOP_LATCHED_ADDR;
   wire logic rd_toplat = bus.rd_stb && bus.addr == lrp_pkg::TOP_LATCHED_ADDR;
   wire logic [9:0] port_ofs = bus.addr - lrp_pkg::PORT_BASE;
   wire logic [5:0] port_reg = port_ofs[5:0];

   // control registers: the pin resets them asynchronously; software reset
   // bit itself is spared by the global reset but cleared by the pin
   always_ff @(posedge clk_in or negedge rst_n_in or posedge pin_rst)
   begin
      if (!rst_n_in || pin_rst)
      begin
         ctl1_ff <= lrp_pkg::TOP_CONTROL_ONE_RST;
         ctl2_ff <= lrp_pkg::TOP_CONTROL_TWO_RST;
         top_en_ff <= lrp_pkg::ENABLE_RST;
      end
      else if (global_rst)
      begin
         // only the software bit survives; data-path bit forced to one
         ctl1_ff <= lrp_pkg::TOP_CONTROL_ONE_RST
                    | (wr_top1 ? {15'h0000, bus.wdata[lrp_pkg::SW_RESET_BIT]}
                               : {15'h0000, ctl1_ff[lrp_pkg::SW_RESET_BIT]});
         ctl2_ff <= lrp_pkg::TOP_CONTROL_TWO_RST;
         top_en_ff <= lrp_pkg::ENABLE_RST;
      end
      else
      begin
         if (wr_top1)
            ctl1_ff <= bus.wdata;
         if (wr_top2)
            ctl2_ff <= bus.wdata;
         if (wr_topen)
            top_en_ff <= bus.wdata;
      end
   end

   // hardware power-down pin synchronisers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         hwtx_sync_ff <= 3'h0;
         hwrx_sync_ff <= 3'h0;
         hw_tx_pd_ff <= 1'b0;
         hw_rx_pd_ff <= 1'b0;
      end
      else
      begin
         hwtx_sync_ff <= {hwtx_sync_ff[1:0], bus.hw_tx_powerdown};
         hwrx_sync_ff <= {hwrx_sync_ff[1:0], bus.hw_rx_powerdown};
         if (hwtx_sync_ff[2] == hwtx_sync_ff[1])
            hw_tx_pd_ff <= hwtx_sync_ff[2];
         if (hwrx_sync_ff[2] == hwrx_sync_ff[1])
            hw_rx_pd_ff <= hwrx_sync_ff[2];
      end
   end

   lrp_latch_reg top_lat (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in & !global_rst), // status cleared by global reset
      .event_in({12'h000, global_event_in}),
      .clear_on_read_in(clr_on_read),
      .rd_in(rd_toplat),
      .wr_in(wr_toplat),
      .wdata_in(bus.wdata),
      .latched_out(top_latched)
   );

   genvar p;
   generate
      for (p = 0; p < NP; p++)
      begin : g_port
         logic [$clog2(lrp_pkg::POWERUP_CYC+1)-1:0] up_cnt_ff;
         logic port_hit;
         logic wr_ctl;
         logic rd_lat;
         logic wr_lat;
         logic rd_blk;
         logic wr_blk;
         logic dp_rst;
         logic txpd;
         logic rxpd;
         assign port_hit = port_sel[p];
         assign wr_ctl = bus.wr_stb && port_hit && port_reg == lrp_pkg::PORT_CONTROL_ONE_OFS;
         assign rd_lat = bus.rd_stb && port_hit && port_reg == lrp_pkg::PORT_LATCHED_OFS;
         assign wr_lat = bus.wr_stb && port_hit && port_reg == lrp_pkg::PORT_LATCHED_OFS;
         assign rd_blk = bus.rd_stb && port_hit && port_reg == lrp_pkg::PORT_BLOCK_STATUS_OFS;
         assign wr_blk = bus.wr_stb && port_hit && port_reg == lrp_pkg::PORT_BLOCK_STATUS_OFS;
         assign port_sel[p] = port_ofs[9:6] == 4'(p);
         // port reset: global reset OR sticky port bit
         assign port_rst[p] = global_rst | (!hw_mode & pctl_ff[p][lrp_pkg::PORT_RESET_BIT]);
         // port data path held by its own bit or by the global one
         assign dp_rst = !hw_mode & (pctl_ff[p][lrp_pkg::PORT_DP_RESET_BIT]
                                     | ctl1_ff[lrp_pkg::DP_RESET_BIT]);
         assign txpd = hw_mode ? hw_tx_pd_ff : pctl_ff[p][lrp_pkg::TX_POWERDOWN_BIT];
         assign rxpd = hw_mode ? hw_rx_pd_ff : pctl_ff[p][lrp_pkg::RX_POWERDOWN_BIT];

         // global reset clears the port bit; port reset spares it
         always_ff @(posedge clk_in or negedge rst_n_in or posedge global_rst)
         begin
            if (!rst_n_in || global_rst)
            begin
               pctl_ff[p] <= lrp_pkg::PORT_CONTROL_ONE_RST;
               pen_ff[p] <= lrp_pkg::ENABLE_RST;
               ben_ff[p] <= lrp_pkg::ENABLE_RST;
            end
            else if (port_rst[p])
            begin
               pctl_ff[p] <= lrp_pkg::PORT_CONTROL_ONE_RST
                             | {15'h0000, wr_ctl ? bus.wdata[0] : pctl_ff[p][0]};
               pen_ff[p] <= lrp_pkg::ENABLE_RST;
               ben_ff[p] <= lrp_pkg::ENABLE_RST;
            end
            else
            begin
               if (wr_ctl)
                  pctl_ff[p] <= bus.wdata;
               if (bus.wr_stb && port_hit && port_reg == lrp_pkg::PORT_INT_ENABLE_OFS)
                  pen_ff[p] <= bus.wdata;
               if (bus.wr_stb && port_hit && port_reg == lrp_pkg::PORT_BLOCK_ENABLE_OFS)
                  ben_ff[p] <= bus.wdata;
            end
         end

         // latched status is data path: cleared by port or data-path reset
         lrp_latch_reg port_lat (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in & !port_rst[p] & !dp_rst),
            .event_in(port_event_in[p]),
            .clear_on_read_in(clr_on_read),
            .rd_in(rd_lat),
            .wr_in(wr_lat),
            .wdata_in(bus.wdata),
            .latched_out(port_latched[p])
         );
         lrp_latch_reg blk_lat (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in & !port_rst[p] & !dp_rst),
            .event_in(block_event_in[p]),
            .clear_on_read_in(clr_on_read),
            .rd_in(rd_blk),
            .wr_in(wr_blk),
            .wdata_in(bus.wdata),
            .latched_out(blk_latched[p])
         );

         // port enable bits 15/14 gate port events and the whole block
         assign port_int[p] = ((|(port_latched[p] & pen_ff[p])) & pen_ff[p][15])
                              | ((|(blk_latched[p] & ben_ff[p])) & pen_ff[p][14]);

         // power-up settling counter restarts whenever a power-down is set
         always_ff @(posedge clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
               up_cnt_ff <= '0;
            else if (txpd || rxpd || port_rst[p])
               up_cnt_ff <= '0;
            else if (up_cnt_ff != lrp_pkg::POWERUP_CYC[$bits(up_cnt_ff)-1:0])
               up_cnt_ff <= up_cnt_ff + 1'b1;
         end

         assign port_ready_out[p] = up_cnt_ff == lrp_pkg::POWERUP_CYC[$bits(up_cnt_ff)-1:0];
         assign tx_powerdown_out[p] = txpd;
         assign rx_powerdown_out[p] = rxpd;
         assign tx_clock_gate_out[p] = txpd | port_rst[p];
         assign rx_clock_gate_out[p] = rxpd | port_rst[p];
         assign line_out_oe_out[p] = !port_rst[p] & !txpd;
         assign port_reset_out[p] = port_rst[p];
         assign port_dp_reset_out[p] = port_rst[p] | dp_rst;
      end
   endgenerate

   // enabled sources summary: global events plus each port
   wire logic top_evt = |(top_latched[3:0] & top_en_ff[3:0]);
   wire logic [15:0] top_status = {8'h00, port_int & top_en_ff[7:4], 3'h0, top_evt};
   wire logic irq = top_en_ff[lrp_pkg::MASTER_EN_BIT] & (|top_status);
   wire logic [1:0] rport = port_ofs[7:6];

   // register read mux; unmapped addresses read zero, except above the last port window, where port_ofs[7:6] aliases ports 0-3
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= bus.rd_stb;
         if (bus.rd_stb)
         begin
            if (bus.addr == lrp_pkg::TOP_CONTROL_ONE_ADDR)
               rdata_ff <= ctl1_ff;
            else if (bus.addr == lrp_pkg::TOP_CONTROL_TWO_ADDR)
               rdata_ff <= ctl2_ff;
            else if (bus.addr == lrp_pkg::TOP_INT_STATUS_ADDR)
               rdata_ff <= top_status;
            else if (bus.addr == lrp_pkg::TOP_LATCHED_ADDR)
               rdata_ff <= top_latched;
            else if (bus.addr == lrp_pkg::TOP_INT_ENABLE_ADDR)
               rdata_ff <= top_en_ff;
            else if (bus.addr >= lrp_pkg::PORT_BASE && port_reg == lrp_pkg::PORT_CONTROL_ONE_OFS)
               rdata_ff <= pctl_ff[rport];
            else if (bus.addr >= lrp_pkg::PORT_BASE && port_reg == lrp_pkg::PORT_INT_STATUS_OFS)
               rdata_ff <= {14'h0000, |blk_latched[rport], |port_latched[rport]};
            else if (bus.addr >= lrp_pkg::PORT_BASE && port_reg == lrp_pkg::PORT_LATCHED_OFS)
               rdata_ff <= port_latched[rport];
            else if (bus.addr >= lrp_pkg::PORT_BASE && port_reg == lrp_pkg::PORT_INT_ENABLE_OFS)
               rdata_ff <= pen_ff[rport];
            else if (bus.addr >= lrp_pkg::PORT_BASE && port_reg == lrp_pkg::PORT_BLOCK_STATUS_OFS)
               rdata_ff <= blk_latched[rport];
            else if (bus.addr >= lrp_pkg::PORT_BASE && port_reg == lrp_pkg::PORT_BLOCK_ENABLE_OFS)
               rdata_ff <= ben_ff[rport];
            else
               rdata_ff <= 16'h0000;
         end
      end
   end

   assign bus.rdata = rdata_ff;
   assign bus.rvalid = rvalid_ff;
   // bus floats on the pin only, never on the software bit
   assign bus.data_oe = {16{rvalid_ff & !pin_rst}};
   // active low when pending, else float or drive high
   assign bus.int_out = !irq;
   assign bus.int_oe = irq | ctl2_ff[lrp_pkg::INT_DRIVE_HIGH_BIT];
   assign global_reset_out = global_rst;
   assign global_dp_reset_out = global_rst | ctl1_ff[lrp_pkg::DP_RESET_BIT];
   // adapter off when its mode field is all zero; global logic has no off
   assign adapter_powerdown_out =
      ctl2_ff[lrp_pkg::ADAPTER_MODE_LSB +: lrp_pkg::ADAPTER_MODE_W] == 7'h00;
   assign one_sec_powerdown_out = !one_sec_ref_present_in;
   assign gp_pins_input_out = pin_rst;
   assign adapter_clock_pins_ref_out = global_rst;
   assign test_reset_out = !bus.test_port_reset_n;
endmodule : lrp_device

// ===== rtl/lrp_host.sv
`timescale 1ns/1ps
// host end: issues single register reads and writes on request,
// and stretches each reset or power-down write to the least hold time
module lrp_host (
   input wire logic clk_in,
   input wire logic rst_n_in,
   lrp_if.host bus,
   input wire logic reset_pin_n_in,
   input wire logic [2:0] interface_select_in,
   input wire logic hw_tx_powerdown_in,
   input wire logic hw_rx_powerdown_in,
   input wire logic req_in,
   input wire logic req_write_in,
   input wire logic [9:0] req_addr_in,
   input wire logic [15:0] req_wdata_in,
   output logic req_ready_out,
   output logic [15:0] resp_data_out,
   output logic resp_valid_out
);
   typedef enum logic [2:0] {
      LRPH_IDLE = 3'b001,
      LRPH_WAIT = 3'b010,
      LRPH_HOLD = 3'b100
   } lrph_state_t;

   lrph_state_t state_ff;
   logic [7:0] hold_ff;
   logic wr_ff;
   logic rd_ff;
   logic [9:0] addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] resp_ff;
   logic resp_v_ff;

   wire logic take = req_in && state_ff == LRPH_IDLE;

   // requests spaced so reset bits stay put at least the least hold
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_ff <= LRPH_IDLE;
         hold_ff <= 8'h00;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= 10'h000;
         wdata_ff <= 16'h0000;
         resp_ff <= 16'h0000;
         resp_v_ff <= 1'b0;
      end
      else
      begin
         wr_ff <= take & req_write_in;
         rd_ff <= take & !req_write_in;
         resp_v_ff <= 1'b0;
         unique case (state_ff)
            LRPH_IDLE:
            begin
               if (req_in)
               begin
                  addr_ff <= req_addr_in;
                  wdata_ff <= req_wdata_in;
                  state_ff <= req_write_in ? LRPH_HOLD : LRPH_WAIT;
                  hold_ff <= 8'(lrp_pkg::MIN_HOLD_CYC);
               end
            end
            LRPH_WAIT:
            begin
               if (bus.rvalid)
               begin
                  resp_ff <= bus.rdata;
                  resp_v_ff <= 1'b1;
                  state_ff <= LRPH_IDLE;
               end
            end
            LRPH_HOLD:
            begin
               if (hold_ff == 8'h00)
                  state_ff <= LRPH_IDLE;
               else
                  hold_ff <= hold_ff - 8'h01;
            end
         endcase
      end
   end

   assign bus.rst_pin_n = reset_pin_n_in;
   assign bus.interface_select = interface_select_in;
   assign bus.hw_tx_powerdown = hw_tx_powerdown_in;
   assign bus.hw_rx_powerdown = hw_rx_powerdown_in;
   assign bus.test_port_reset_n = rst_n_in;
   assign bus.wr_stb = wr_ff;
   assign bus.rd_stb = rd_ff;
   assign bus.addr = addr_ff;
   assign bus.wdata = wdata_ff;
   assign req_ready_out = state_ff == LRPH_IDLE;
   assign resp_data_out = resp_ff;
   assign resp_valid_out = resp_v_ff;
endmodule : lrp_host

// ===== rtl/lrp_if.sv
`timescale 1ns/1ps
interface lrp_if;
   logic rst_pin_n; // external reset pin, active low
   logic [2:0] interface_select;
   logic hw_tx_powerdown;
   logic hw_rx_powerdown;
   logic test_port_reset_n;
   logic wr_stb; // one-cycle register write
   logic rd_stb; // one-cycle register read
   logic [9:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic rvalid;
   logic [15:0] data_oe; // processor data bus drive enable
   logic int_out; // interrupt pin level
   logic int_oe; // interrupt pin drive enable
   modport dev (
      input rst_pin_n, interface_select, hw_tx_powerdown, hw_rx_powerdown,
      input test_port_reset_n, wr_stb, rd_stb, addr, wdata,
      output rdata, rvalid, data_oe, int_out, int_oe
   );
   modport host (
      output rst_pin_n, interface_select, hw_tx_powerdown, hw_rx_powerdown,
      output test_port_reset_n, wr_stb, rd_stb, addr, wdata,
      input rdata, rvalid, data_oe, int_out, int_oe
   );
endinterface : lrp_if

// ===== rtl/lrp_latch_reg.sv
`timescale 1ns/1ps
// one 16-bit latched status register with clear-on-read or write-one-clear
module lrp_latch_reg (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [15:0] event_in,
   input wire logic clear_on_read_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] latched_out
);
   logic [15:0] latched_ff;
   logic [15:0] evt_prev_ff;
   wire logic [15:0] rise = event_in & ~evt_prev_ff;
   wire logic [15:0] clr_mask = clear_on_read_in ? {16{rd_in}} : (wr_in ? wdata_in : 16'h0000);
   // a new event wins over a clear in the same cycle
   wire logic [15:0] nxt_latched = (latched_ff & ~clr_mask) | rise;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         latched_ff <= 16'h0000;
         evt_prev_ff <= 16'h0000;
      end
      else
      begin
         latched_ff <= nxt_latched;
         evt_prev_ff <= event_in;
      end
   end

   assign latched_out = latched_ff;
endmodule : lrp_latch_reg

// ===== rtl/lrp_pkg.sv
package lrp_pkg;
   // port count and register geometry
   localparam int NUM_PORTS = 4;
   localparam int REG_W = 16;
   localparam int ADDR_W = 10;
   // global register offsets (byte addresses, 16-bit registers)
   localparam logic [9:0] TOP_INT_STATUS_ADDR = 10'h010;
   localparam logic [9:0] TOP_CONTROL_ONE_ADDR = 10'h002;
   localparam logic [9:0] TOP_CONTROL_TWO_ADDR = 10'h004;
   localparam logic [9:0] TOP_LATCHED_ADDR = 10'h012;
   localparam logic [9:0] TOP_INT_ENABLE_ADDR = 10'h014;
   // port window: base = PORT_BASE + port * PORT_STRIDE
   localparam logic [9:0] PORT_BASE = 10'h100;
   localparam logic [9:0] PORT_STRIDE = 10'h040;
   localparam logic [5:0] PORT_CONTROL_ONE_OFS = 6'h00;
   localparam logic [5:0] PORT_INT_STATUS_OFS = 6'h02;
   localparam logic [5:0] PORT_LATCHED_OFS = 6'h04;
   localparam logic [5:0] PORT_INT_ENABLE_OFS = 6'h06;
   localparam logic [5:0] PORT_BLOCK_STATUS_OFS = 6'h08;
   localparam logic [5:0] PORT_BLOCK_ENABLE_OFS = 6'h0A;
   // top_control_one fields
   localparam int SW_RESET_BIT = 0;
   localparam int DP_RESET_BIT = 1;
   // top_control_two fields
   localparam int LATCH_CLEAR_READ_BIT = 15;
   localparam int INT_DRIVE_HIGH_BIT = 4;
   localparam int ADAPTER_MODE_LSB = 8;
   localparam int ADAPTER_MODE_W = 7;
   // port_control_one fields
   localparam int PORT_RESET_BIT = 0;
   localparam int PORT_DP_RESET_BIT = 1;
   localparam int TX_POWERDOWN_BIT = 2;
   localparam int RX_POWERDOWN_BIT = 3;
   // port_interrupt_status fields: bit 0 = port events, bit 1 = block
   localparam int PORT_EVT_BIT = 0;
   localparam int PORT_BLK_BIT = 1;
   // top_interrupt_status: bit 0 global events, bits 4+p ports
   localparam int TOP_EVT_BIT = 0;
   localparam int TOP_PORT_LSB = 4;
   // top_interrupt_enable: bit 15 global master enable
   localparam int MASTER_EN_BIT = 15;
   // reset values
   localparam logic [15:0] TOP_CONTROL_ONE_RST = 16'h0002;
   localparam logic [15:0] TOP_CONTROL_TWO_RST = 16'h0000;
   localparam logic [15:0] PORT_CONTROL_ONE_RST = 16'h000E;
   localparam logic [15:0] ENABLE_RST = 16'h0000;
   // timing: least hold of reset bits, power-up settle time
   localparam int CLK_NS = 100;
   localparam int MIN_HOLD_NS = 100;
   localparam int MIN_HOLD_CYC = (MIN_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWERUP_US = 1000;
   localparam int POWERUP_CYC = POWERUP_US * 1000 / CLK_NS;
   // interface selection
   localparam logic [1:0] IF_SEL_HW = 2'b00;
endpackage : lrp_pkg

// ===== tb/lrp_sva.sv
`timescale 1ns/1ps
// bus handshake and reset-pin checks seen on the shared interface
module lrp_sva (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic rst_pin_n,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic rvalid,
   input wire logic [15:0] data_oe
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_read_answered: assert property (rd_stb |=> rvalid)
      else $error("read without answer");
   a_answer_cause: assert property (rvalid |-> $past(rd_stb))
      else $error("answer without read");
   a_answer_single: assert property (rvalid |=> !rvalid)
      else $error("answer stretched");
   a_bus_floats: assert property (!rst_pin_n |-> data_oe == 16'h0000)
      else $error("bus driven in pin reset");
   a_drive_answer: assert property (data_oe != 16'h0000 |-> rvalid)
      else $error("bus driven without answer");
   a_drive_word: assert property (rvalid && rst_pin_n |-> data_oe == 16'hFFFF)
      else $error("partial word drive");
   a_strobe_excl: assert property (!(wr_stb && rd_stb))
      else $error("read and write together");
   a_write_hold: assert property (wr_stb |=> !wr_stb [*2])
      else $error("writes too close");
   c_read: cover property (rd_stb ##1 rvalid);
   c_write: cover property (wr_stb);
   c_pin_reset: cover property (!rst_pin_n ##1 rst_pin_n);
endmodule : lrp_sva

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic pin_n = 1'h1;
   logic [2:0] isel = 3'h4;
   logic hw_tx = 1'h0, hw_rx = 1'h0;
   logic req = 1'h0;
   logic req_wr = 1'h0;
   logic [9:0] req_addr = 10'h000;
   logic [15:0] req_wdata = 16'h0000;
   logic ready, resp_v, gr, gp, gdp, apd;
   logic [15:0] resp, d;
   logic [3:0] gev = 4'h0;
   logic [15:0] pev [lrp_pkg::NUM_PORTS] = '{default: 16'h0000};
   logic [3:0] tx_pd, rx_pd, rdy, loe, prst, tcg;
   logic [15:0] mdl [int];
   int err_count = 0;
   int checks_done = 0;
   int p;
   lrp_if u_if ();
   lrp_sva u_lrp_sva (.clk_in(clk_in), .rst_n_in(rst_n_in), .rst_pin_n(u_if.rst_pin_n),
      .wr_stb(u_if.wr_stb), .rd_stb(u_if.rd_stb), .rvalid(u_if.rvalid), .data_oe(u_if.data_oe));
   lrp_device u_lrp_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(u_if.dev),
      .global_event_in(gev), .port_event_in(pev), .block_event_in(pev),
      .one_sec_ref_present_in(1'h1), .tx_clock_gate_out(tcg), .rx_clock_gate_out(),
      .tx_powerdown_out(tx_pd), .rx_powerdown_out(rx_pd), .port_ready_out(rdy),
      .line_out_oe_out(loe), .port_reset_out(prst), .port_dp_reset_out(),
      .global_reset_out(gr), .global_dp_reset_out(gdp), .adapter_powerdown_out(apd),
      .one_sec_powerdown_out(), .gp_pins_input_out(gp), .adapter_clock_pins_ref_out(),
      .test_reset_out());
   lrp_host u_lrp_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(u_if.host),
      .reset_pin_n_in(pin_n), .interface_select_in(isel), .hw_tx_powerdown_in(hw_tx),
      .hw_rx_powerdown_in(hw_rx), .req_in(req), .req_write_in(req_wr), .req_addr_in(req_addr),
      .req_wdata_in(req_wdata), .req_ready_out(ready), .resp_data_out(resp),
      .resp_valid_out(resp_v));
   // 100 ns clock
   initial forever #50 clk_in = ~clk_in;
   task automatic wrap_up;
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one host request; a write completes when the host is ready again
   task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] v);
      int n;
      n = 0;
      @(negedge clk_in);
      while (ready !== 1'h1 && n < 50)
      begin
         @(negedge clk_in);
         n++;
      end
      {req, req_wr, req_addr, req_wdata} = {1'h1, w, a, v};
      @(negedge clk_in);
      req = 1'h0;
      while ((w ? ready : resp_v) !== 1'h1 && n < 100)
      begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 50)
      begin
         err_count++;
         wrap_up();
      end
   endtask : acc
   task automatic rd(input logic [9:0] a);
      acc(1'h0, a, 16'h0000);
      chk($sformatf("reg %h", a), resp, mdl[a]);
   endtask : rd
   function automatic logic [9:0] pa(input int q);
      return lrp_pkg::PORT_BASE + 10'(q) * lrp_pkg::PORT_STRIDE;
   endfunction : pa
   // main sequence; the model holds the expected control word before each read back
   initial
   begin
      void'($urandom(32'h1D73BEE1));
      repeat (8) @(posedge clk_in);
      @(negedge clk_in) rst_n_in = 1'h1;
      mdl[10'h002] = 16'h0002;
      for (int q = 0; q < 4; q++) mdl[pa(q)] = 16'h000E;
      for (int q = 0; q < 4; q++) rd(pa(q));
      rd(10'h002);
      chk("tx_pd", 16'(tx_pd), 16'h000F);
      chk("dp_glob", 16'({gdp, apd}), 16'h0003);
      acc(1'h1, 10'h002, 16'h0001);
      mdl[10'h002] = 16'h0003;
      rd(10'h002);
      chk("glob_rst", 16'(gr), 16'h0001);
      chk("port_rst", 16'(prst), 16'h000F);
      acc(1'h1, 10'h002, 16'h0000);
      acc(1'h1, 10'h002, 16'h0000);
      mdl[10'h002] = 16'h0000;
      rd(10'h002);
      chk("dp_glob_off", 16'(gdp), 16'h0000);
      p = $urandom_range(3);
      acc(1'h1, pa(p), 16'h0001);
      mdl[pa(p)] = 16'h000F;
      rd(pa(p));
      chk("one_port_rst", 16'(prst), 16'(4'h1 << p));
      acc(1'h1, pa(p), 16'h0000);
      acc(1'h1, pa(p), 16'h0000);
      mdl[pa(p)] = 16'h0000;
      rd(pa(p));
      for (int q = 0; q < 4; q++)
      begin
         // power-down bits change while the port data path stays held
         d = (16'($urandom) & 16'h000C) | 16'h0002;
         acc(1'h1, pa(q), d);
         mdl[pa(q)] = d;
         rd(pa(q));
         chk("pd", 16'({tx_pd[q], rx_pd[q]}), 16'({d[2], d[3]}));
         chk("gate", 16'(tcg[q]), 16'(d[2]));
      end
      // power up first, then release the data path
      acc(1'h1, pa(0), 16'h000E);
      acc(1'h1, pa(0), 16'h0002);
      acc(1'h1, pa(0), 16'h0000);
      chk("not_ready", 16'(rdy[0]), 16'h0000);
      repeat (lrp_pkg::POWERUP_CYC + 5) @(negedge clk_in);
      chk("ready", 16'(rdy[0]), 16'h0001);
      // the event line stays high, so the last check shows a held level does not latch again
      acc(1'h1, lrp_pkg::TOP_INT_ENABLE_ADDR, 16'h8001);
      gev = 4'h1;
      repeat (4) @(negedge clk_in);
      chk("irq", {u_if.int_oe, u_if.int_out}, 16'h0002);
      acc(1'h1, lrp_pkg::TOP_INT_ENABLE_ADDR, 16'h0001);
      chk("masked", 16'(u_if.int_oe), 16'h0000);
      acc(1'h1, lrp_pkg::TOP_INT_ENABLE_ADDR, 16'h8001);
      acc(1'h1, lrp_pkg::TOP_LATCHED_ADDR, 16'h0001);
      chk("cleared", 16'(u_if.int_oe), 16'h0000);
      acc(1'h1, 10'h002, 16'h0001);
      pin_n = 1'h0;
      repeat (2) @(negedge clk_in);
      chk("pin_rst", {gr, gp, loe}, 16'h0030);
      mdl[10'h002] = 16'h0002;
      rd(10'h002);
      chk("bus_oe", u_if.data_oe, 16'h0000);
      pin_n = 1'h1;
      rd(10'h002);
      {isel, hw_tx} = {3'h0, 1'h1};
      repeat (5) @(negedge clk_in);
      chk("hw_pd", {tx_pd, rx_pd}, 16'h00F0);
      {hw_tx, hw_rx} = 2'h1;
      repeat (5) @(negedge clk_in);
      chk("hw_rpd", {tx_pd, rx_pd}, 16'h000F);
      wrap_up();
   end
endmodule : testbench
